/* File: core/mcca_top.sv */
// Motor control configuration register A with its side effects, AXI4-Lite slave
`timescale 1ns/100ps
module mcca_top (
   // Clock, enable and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Option bits and zero-crossing inputs
   input wire logic [11:0] output_reset_option,
   input wire logic zc_pin,
   input wire logic [7:0] zc_capture_value,
   // Motor drive outputs
   output logic [5:0] motor_drive_outputs,
   output logic [5:0] motor_drive_outputs_oe,
   // Mode and clocking status
   output logic periph_clk_en,
   output logic sensor_select,
   output logic regulation_mode_select,
   output logic parasitic_zc_guard,
   output logic [3:0] zero_filter_eff,
   output logic [7:0] mult_operand,
   output logic zc_sampling_run,
   output logic demag_sampling_run,
   output logic commutation_event
);
   typedef struct packed {
      logic [7:0] config_a;
      logic [7:0] phase_pre;
      logic [7:0] phase_act;
      logic [7:0] ctrl_b_pre;
      logic [7:0] ctrl_b_act;
      logic [7:0] sampler;
      logic [7:0] filter;
      logic [7:0] ctrl_c;
      logic [7:0] compare;
      logic [7:0] timer;
      logic [7:0] prev_zc;
      logic [7:0] last_zc;
      logic armed;
      logic comm;
      logic match_seen;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mcca_state_t;
   mcca_state_t q;
   mcca_state_t next_q;
   logic zc_level;
   logic cmp_match;
   logic do_write;
   logic wr_lane0;
   logic [7:0] wbyte;
   logic clk_on;
   logic comm_now;
   logic [7:0] rd_byte;
   logic rd_ok;
   mcca_sync_if zc_if ();
   assign zc_if.raw = zc_pin;
   assign zc_level = zc_if.level;
   mcca_sync u_zc_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .s(zc_if)
   );
   assign clk_on = q.config_a[mcca_pkg::BIT_CLK_EN];
   assign do_write = q.aw_got && q.w_got && !q.bvalid;
   assign wr_lane0 = do_write && q.w_strb[0];
   assign wbyte = q.w_data[7:0];
   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         mcca_pkg::ADDR_CONFIG_A: rd_byte = q.config_a;
         mcca_pkg::ADDR_PHASE_STATE: rd_byte = q.phase_pre;
         mcca_pkg::ADDR_CONTROL_B: rd_byte = q.ctrl_b_pre;
         mcca_pkg::ADDR_SAMPLER: rd_byte = q.sampler;
         mcca_pkg::ADDR_FILTER: rd_byte = q.filter;
         mcca_pkg::ADDR_CONTROL_C: rd_byte = q.ctrl_c;
         mcca_pkg::ADDR_COMPARE: rd_byte = q.compare;
         mcca_pkg::ADDR_TIMER: rd_byte = q.timer;
         mcca_pkg::ADDR_STATUS: rd_byte = {6'h00, q.armed, clk_on};
         mcca_pkg::ADDR_PREV_ZC: rd_byte = q.prev_zc;
         mcca_pkg::ADDR_LAST_ZC: rd_byte = q.last_zc;
         default: begin
            rd_byte = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
   end
   // A compare match commutes once, on entry into the match, not on every cycle it lasts
   assign cmp_match = clk_on && q.config_a[mcca_pkg::BIT_AUTO_SW] && q.timer == q.compare;
   // Commutation on compare match while autoswitched and clocked, or direct phase write
   always_comb begin
      comm_now = 1'b0;
      if (cmp_match && !q.match_seen) begin
         comm_now = 1'b1;
      end
      if (wr_lane0 && q.aw_addr == mcca_pkg::ADDR_PHASE_STATE && q.config_a[mcca_pkg::BIT_DIRECT]) begin
         comm_now = 1'b1;
      end
   end
   always_comb begin
      next_q = q;
      if (ce) begin
         next_q.comm = comm_now;
         next_q.match_seen = cmp_match || comm_now;
         if (s_axi_awvalid && s_axi_awready) begin
            next_q.aw_got = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            next_q.w_got = 1'b1;
            next_q.w_data = s_axi_wdata;
            next_q.w_strb = s_axi_wstrb;
         end
         // Peripheral clock gates the timer; writes below still land
         if (clk_on && q.config_a[mcca_pkg::BIT_AUTO_SW]) begin
            next_q.timer = q.timer + 8'h01;
         end
         if (comm_now) begin
            next_q.armed = 1'b1;
            next_q.timer = 8'h00;
            if (!q.config_a[mcca_pkg::BIT_DIRECT] && clk_on) begin
               next_q.phase_act = q.phase_pre;
               next_q.ctrl_b_act = q.ctrl_b_pre;
            end
         end
         // Zero-crossing capture history, only while clocked and sampling
         if (clk_on && zc_sampling_run && zc_level != q.sampler[7]) begin
            next_q.prev_zc = q.last_zc;
            next_q.last_zc = zc_capture_value;
            next_q.sampler[7] = zc_level;
         end
         if (do_write) begin
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = mcca_pkg::RESP_OKAY;
            if (wr_lane0) begin
               case (q.aw_addr)
                  mcca_pkg::ADDR_CONFIG_A: next_q.config_a = wbyte;
                  mcca_pkg::ADDR_PHASE_STATE: begin
                     next_q.phase_pre = wbyte;
                     if (q.config_a[mcca_pkg::BIT_DIRECT]) begin
                        next_q.phase_act = wbyte;
                     end
                  end
                  mcca_pkg::ADDR_CONTROL_B: next_q.ctrl_b_pre = wbyte;
                  mcca_pkg::ADDR_SAMPLER: next_q.sampler[6:0] = wbyte[6:0];
                  mcca_pkg::ADDR_FILTER: next_q.filter = wbyte;
                  mcca_pkg::ADDR_CONTROL_C: next_q.ctrl_c = wbyte;
                  mcca_pkg::ADDR_COMPARE: next_q.compare = wbyte;
                  mcca_pkg::ADDR_TIMER: next_q.timer = wbyte;
                  mcca_pkg::ADDR_STATUS: next_q.bresp = mcca_pkg::RESP_OKAY;
                  mcca_pkg::ADDR_PREV_ZC: next_q.bresp = mcca_pkg::RESP_OKAY;
                  mcca_pkg::ADDR_LAST_ZC: next_q.bresp = mcca_pkg::RESP_OKAY;
                  default: next_q.bresp = mcca_pkg::RESP_SLVERR;
               endcase
            end
         end
         if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            next_q.rvalid = 1'b1;
            next_q.rdata = {24'h000000, rd_byte};
            next_q.rresp = rd_ok ? mcca_pkg::RESP_OKAY : mcca_pkg::RESP_SLVERR;
         end else if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   // Drive outputs: per-pin reset state from two option bits each
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (q.config_a[mcca_pkg::BIT_OUT_EN]) begin
            motor_drive_outputs[i] = q.phase_act[i];
            motor_drive_outputs_oe[i] = 1'b1;
         end else begin
            motor_drive_outputs[i] = (output_reset_option[2*i +: 2] == mcca_pkg::OPT_HIGH);
            motor_drive_outputs_oe[i] = (output_reset_option[2*i +: 2] != mcca_pkg::OPT_HIZ);
         end
      end
   end
   assign periph_clk_en = clk_on;
   assign sensor_select = q.config_a[mcca_pkg::BIT_SENSOR];
   assign regulation_mode_select = q.config_a[mcca_pkg::BIT_REG_MODE];
   assign parasitic_zc_guard = q.config_a[mcca_pkg::BIT_ZC_GUARD];
   assign zero_filter_eff = parasitic_zc_guard ? 4'h0 : q.filter[3:0];
   assign mult_operand = q.config_a[mcca_pkg::BIT_CAPT_SRC] ? q.last_zc : q.prev_zc;
   always_comb begin
      zc_sampling_run = clk_on;
      if (!q.config_a[mcca_pkg::BIT_OUT_EN] && !q.config_a[mcca_pkg::BIT_SENSOR]
          && !q.ctrl_c[mcca_pkg::BIT_RATE_SEL]) begin
         zc_sampling_run = clk_on && q.sampler[mcca_pkg::BIT_ZS_KEEP];
      end
   end
   assign demag_sampling_run = clk_on;
   assign commutation_event = q.comm;
   // No new write is taken while a response waits
   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready = !q.w_got && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
endmodule

/* File: common/mcca_pkg.sv */
// Package with register map, field positions and reset values of the motor configuration block
package mcca_pkg;
   localparam logic [7:0] ADDR_CONFIG_A = 8'h00;
   localparam logic [7:0] ADDR_PHASE_STATE = 8'h04;
   localparam logic [7:0] ADDR_CONTROL_B = 8'h08;
   localparam logic [7:0] ADDR_SAMPLER = 8'h0C;
   localparam logic [7:0] ADDR_FILTER = 8'h10;
   localparam logic [7:0] ADDR_CONTROL_C = 8'h14;
   localparam logic [7:0] ADDR_COMPARE = 8'h18;
   localparam logic [7:0] ADDR_TIMER = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_PREV_ZC = 8'h24;
   localparam logic [7:0] ADDR_LAST_ZC = 8'h28;
   localparam int BIT_OUT_EN = 7;
   localparam int BIT_CLK_EN = 6;
   localparam int BIT_SENSOR = 5;
   localparam int BIT_DIRECT = 4;
   localparam int BIT_REG_MODE = 3;
   localparam int BIT_AUTO_SW = 2;
   localparam int BIT_ZC_GUARD = 1;
   localparam int BIT_CAPT_SRC = 0;
   localparam int BIT_ZS_KEEP = 0;
   localparam int BIT_RATE_SEL = 0;
   localparam logic [7:0] RESET_CONFIG_A = 8'h00;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] OPT_HIZ = 2'h0;
   localparam logic [1:0] OPT_HIGH = 2'h1;
   localparam logic [1:0] OPT_LOW = 2'h2;
endpackage

/* File: common/mcca_sync_if.sv */
// Interface carrying one synchronised input and its agreed level
`timescale 1ns/100ps
interface mcca_sync_if;
   logic raw;
   logic level;
   modport sync (input raw, output level);
   modport user (output raw, input level);
endinterface

/* File: core/mcca_sync.sv */
// Three-stage synchroniser; level changes once stages two and three agree
`timescale 1ns/100ps
module mcca_sync (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Signal
   mcca_sync_if.sync s
);
   typedef struct packed {
      logic [2:0] stg;
      logic level;
   } mcca_sync_t;
   mcca_sync_t q;
   mcca_sync_t next_q;
   always_comb begin
      next_q = q;
      if (ce) begin
         next_q.stg = {q.stg[1:0], s.raw};
         if (q.stg[1] == q.stg[2]) begin
            next_q.level = q.stg[2];
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   assign s.level = q.level;
endmodule

/* File: verification/mcca_top_properties.sv */
// Checker of handshakes and mode outputs of the motor configuration block
`timescale 1ns/100ps
module mcca_props (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Mode outputs
   input wire logic parasitic_zc_guard,
   input wire logic [3:0] zero_filter_eff,
   input wire logic commutation_event
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_b_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_r_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_wr_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   chk_wr_block:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while one pending");
   chk_rd_block:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while one pending");
   chk_guard_filter:
      assert property (parasitic_zc_guard |-> zero_filter_eff == 4'h0)
      else $error("filter not ignored under guard");
   chk_comm_pulse:
      assert property (commutation_event |=> !commutation_event)
      else $error("commutation pulse too long");
   chk_rst_quiet:
      assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid)
      else $error("response during reset");
endmodule
bind mcca_top mcca_props chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .parasitic_zc_guard, .zero_filter_eff, .commutation_event);

/* File: verification/mcca_motor_model.sv */
// Power stage and rotor feedback model
`timescale 1ns/100ps
module mcca_motor_model (
   // Clock
   input wire logic aclk,
   // Inverter drive
   input wire logic [5:0] drv,
   input wire logic [5:0] drv_oe,
   // Feedback
   input wire logic zc_step,
   output logic zc_pin = 1'b0,
   output logic [7:0] zc_capture_value = 8'h00,
   output logic [5:0] phase
);
   // Released gates float
   always_comb for (int i = 0; i < 6; i++) phase[i] = drv_oe[i] ? drv[i] : 1'bz;
   // Each step is one zero crossing with a fresh capture
   always @(posedge aclk) begin
      if (zc_step) begin
         zc_pin <= !zc_pin;
         zc_capture_value <= zc_capture_value + 8'h11;
      end
   end
endmodule

/* File: verification/mcca_top_tb.sv */
// Testbench of the motor configuration block
`timescale 1ns/100ps
module mcca_top_tb;
   logic aclk = 0, aresetn = 0, ce = 1, zc_step = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, zc_capture_value, mult_operand;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, zero_filter_eff;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, zc_pin, commutation_event;
   logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen, rresp_seen;
   logic [11:0] output_reset_option = 12'h924;
   logic [5:0] motor_drive_outputs, motor_drive_outputs_oe;
   logic periph_clk_en, sensor_select, regulation_mode_select, parasitic_zc_guard;
   logic zc_sampling_run, demag_sampling_run;
   int error_cnt = 0, n_compared = 0, n_comm = 0, n0 = 0, cyc = 0;
   mcca_top dut_u (.*);
   mcca_motor_model model_u (.aclk, .drv(motor_drive_outputs), .drv_oe(motor_drive_outputs_oe), .zc_step,
      .zc_pin, .zc_capture_value, .phase());
   initial begin
      forever #50 aclk = !aclk;
   end
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'hFFFFFF, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      bresp_seen = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rresp_seen = s_axi_rresp;
      s_axi_rready <= 0;
      chk(s_axi_rdata, exp);
   endtask
   always @(posedge aclk) begin
      if (commutation_event === 1'b1) n_comm++;
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      rd_chk(8'h00, 32'h0);
      wr(8'h00, 8'h44);
      repeat (4) @(posedge aclk);
      chk(n_comm, 1);
      wr(8'h00, 8'h00);
      chk({motor_drive_outputs_oe, motor_drive_outputs & motor_drive_outputs_oe}, 12'hD92);
      for (int i = 0; i < 8; i++) begin
         wr(8'h00, 8'h01 << i);
         rd_chk(8'h00, 32'h1 << i);
         chk({periph_clk_en, sensor_select, regulation_mode_select, parasitic_zc_guard},
            {i == 6, i == 5, i == 3, i == 1});
      end
      wr(8'h10, 8'h0F);
      chk(zero_filter_eff, 4'hF);
      wr(8'h00, 8'h02);
      chk(zero_filter_eff, 4'h0);
      wr(8'h00, 8'h00);
      wr(8'h1C, 8'h33);
      rd_chk(8'h1C, 32'h33);
      wr(8'h00, 8'h40);
      for (int k = 0; k < 2; k++) begin
         wr(8'h0C, k[7:0]);
         chk({zc_sampling_run, demag_sampling_run}, {k == 1, 1'b1});
      end
      for (int j = 0; j < 2; j++) begin
         @(posedge aclk);
         zc_step <= 1;
         @(posedge aclk);
         zc_step <= 0;
         repeat (8) @(posedge aclk);
      end
      wr(8'h00, 8'h00);
      chk(mult_operand, 8'h11);
      wr(8'h00, 8'h01);
      chk(mult_operand, 8'h22);
      rd_chk(8'hFC, 32'h0);
      chk(rresp_seen, mcca_pkg::RESP_SLVERR);
      wr(8'hFC, 8'h5A);
      chk(bresp_seen, mcca_pkg::RESP_SLVERR);
      wr(8'h00, 8'hD0);
      chk(bresp_seen, mcca_pkg::RESP_OKAY);
      n0 = n_comm;
      wr(8'h04, 8'h2A);
      repeat (2) @(posedge aclk);
      chk(motor_drive_outputs, 6'h2A);
      chk(n_comm - n0, 1);
      wr(8'h00, 8'hC0);
      wr(8'h04, 8'h15);
      chk(motor_drive_outputs, 6'h2A);
      wr(8'h00, 8'hC4);
      n0 = n_comm;
      while (n_comm == n0) @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk(motor_drive_outputs, 6'h15);
      test_done();
   end
endmodule
